// file: verilog/hsp_host_port.sv
`timescale 1ns/1ps
module hsp_host_port
    import hsp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        serial_clock,
    input  wire logic        chip_select_b,
    input  wire logic        serial_in,
    output logic             serial_out,
    input  wire hsp_sig_type sig_ch1,
    input  wire hsp_sig_type sig_ch2,
    input  wire logic        test_data_alert_mode,
    input  wire logic        int_open_drain,
    input  wire logic [15:0] test_data,
    input  wire logic [7:0]  reg_read_data,
    output logic             int_pin_out,
    output logic             int_pin_oe,
    output logic             voice_ch1_enable,
    output logic             voice_ch2_enable,
    output logic             reg_write,
    output logic [7:0]       reg_cmd,
    output logic [7:0]       reg_data,
    output logic             device_reset
);

    // ========================================================
    // link side, rising edge: shift in and count edges
    hsp_link_type lp;
    logic [7:0]   out_gray;

    // select high freezes everything, so a shared clock is harmless
    always_ff @(posedge serial_clock or negedge rst_b) begin
        if (!rst_b) begin
            lp <= '0;
        end else if (!chip_select_b) begin
            lp.shift     <= {lp.shift[6:0], serial_in};
            lp.rise_cnt  <= lp.rise_cnt + 8'h01;
            lp.rise_gray <= bin2gray(lp.rise_cnt + 8'h01);
        end
    end

    // ========================================================
    // link side, falling edge: advance output bit position
    // copies the rising count, so the index moves only after a sample
    always_ff @(negedge serial_clock or negedge rst_b) begin
        if (!rst_b) begin
            out_gray <= '0;
        end else if (!chip_select_b) begin
            out_gray <= lp.rise_gray;
        end
    end

    // ========================================================
    // read data selection for one output byte
    function automatic logic [7:0] read_byte(
        input logic [7:0]  cmd,
        input logic [1:0]  idx,
        input hsp_sig_type s1,
        input hsp_sig_type s2,
        input logic [15:0] mask,
        input logic [7:0]  ch_en,
        input logic [15:0] test,
        input logic [7:0]  ext
    );
        logic [7:0] r;
        r = 8'h00;
        if (cmd == CMD_RD_SIG || cmd == CMD_RD_SIG_CLR) begin
            r = (idx == 2'h0) ? s1 : s2;
        end else if (cmd == CMD_RD_MASK) begin
            r = (idx == 2'h0) ? mask[15:8] : mask[7:0];
        end else if (cmd == CMD_RD_CHAN_EN) begin
            r = ch_en;
        end else if (cmd == CMD_RD_TEST) begin
            r = (idx == 2'h0) ? test[15:8] : test[7:0];
        end else begin
            r = ext;
        end
        return r;
    endfunction : read_byte

    // number of data bytes after a command
    function automatic logic [1:0] cmd_len(input logic [7:0] cmd);
        logic [1:0] n;
        n = 2'h1;
        if (cmd == CMD_RD_SIG || cmd == CMD_RD_SIG_CLR ||
            cmd == CMD_WR_MASK || cmd == CMD_RD_MASK ||
            cmd == CMD_RD_TEST) begin
            n = 2'h2;
        end
        return n;
    endfunction : cmd_len

    // ========================================================
    // system side state
    hsp_sys_type s;
    hsp_sys_type next_s;

    logic        cs_fall;
    logic        cs_rise;
    logic        eval;
    logic [7:0]  base;
    logic [7:0]  edges;
    logic [7:0]  out_idx;
    logic [7:0]  rx_byte;
    logic [15:0] status_now;
    logic [15:0] changed;
    logic        int_set;
    logic        int_clr;

    always_comb begin
        next_s  = s;
        int_clr = 1'b0;
        // two-stage synchronisers; only stage two is read
        next_s.cs_s1     = chip_select_b;
        next_s.cs_s2     = s.cs_s1;
        next_s.cs_d      = s.cs_s2;
        next_s.rise_s1   = lp.rise_gray;
        next_s.rise_s2   = s.rise_s1;
        next_s.out_s1    = out_gray;
        next_s.out_s2    = s.out_s1;
        next_s.shift_s1  = lp.shift;
        next_s.shift_s2  = s.shift_s1;
        next_s.reg_write = 1'b0;
        next_s.dev_reset = 1'b0;

        cs_fall = s.cs_d & ~s.cs_s2;
        cs_rise = ~s.cs_d & s.cs_s2;
        base    = cs_fall ? gray2bin(s.rise_s2) : s.rise_base;
        next_s.rise_base = base;

        // let the last edge's data settle before judging the frame
        eval = 1'b0;
        if (cs_rise) begin
            next_s.settle = SETTLE_CYCLES;
        end else if (s.settle != 2'h0) begin
            next_s.settle = s.settle - 2'h1;
            eval = (s.settle == 2'h1);
        end
        edges   = gray2bin(s.rise_s2) - s.rise_base;
        rx_byte = s.shift_s2;

        // --------------------------------------------------
        // byte handling per frame
        if (eval && edges >= RESET_EDGES) begin
            next_s.mode      = HSP_CMD;
            next_s.cmd       = 8'h00;
            next_s.left      = 2'h0;
            next_s.idx       = 2'h0;
            next_s.tx_byte   = 8'h00;
            next_s.ch_en     = CHAN_EN_RESET;
            next_s.mask      = MASK_RESET;
            next_s.dev_reset = 1'b1;
            int_clr          = 1'b1;
        end else if (eval && edges >= MIN_BYTE_EDGES) begin
            case (s.mode)
                HSP_CMD: begin
                    next_s.cmd  = rx_byte;
                    next_s.left = cmd_len(rx_byte);
                    next_s.idx  = 2'h0;
                    if (rx_byte[0]) begin
                        next_s.mode    = HSP_READ;
                        next_s.tx_byte = read_byte(rx_byte, 2'h0,
                            sig_ch1, sig_ch2, s.mask, s.ch_en,
                            test_data, reg_read_data);
                    end else begin
                        next_s.mode = HSP_WRITE;
                    end
                    // plain signaling read never clears
                    if (rx_byte == CMD_RD_SIG_CLR) begin
                        int_clr = 1'b1;
                    end else if (rx_byte == CMD_RD_TEST &&
                                 test_data_alert_mode) begin
                        int_clr = 1'b1;
                    end
                end
                HSP_WRITE: begin
                    if (s.cmd == CMD_WR_CHAN_EN) begin
                        next_s.ch_en = rx_byte;
                    end else if (s.cmd == CMD_WR_MASK) begin
                        if (s.idx == 2'h0) begin
                            next_s.mask[15:8] = rx_byte;
                        end else begin
                            next_s.mask[7:0] = rx_byte;
                        end
                    end else begin
                        next_s.reg_write = 1'b1;
                        next_s.reg_data  = rx_byte;
                    end
                    next_s.idx  = s.idx + 2'h1;
                    next_s.left = s.left - 2'h1;
                    if (s.left == 2'h1) begin
                        next_s.mode = HSP_CMD;
                    end
                end
                HSP_READ: begin
                    // incoming bits are not commands here
                    next_s.idx  = s.idx + 2'h1;
                    next_s.left = s.left - 2'h1;
                    if (s.left == 2'h1) begin
                        next_s.mode    = HSP_CMD;
                        next_s.tx_byte = 8'h00;
                    end else begin
                        next_s.tx_byte = read_byte(s.cmd,
                            s.idx + 2'h1, sig_ch1, sig_ch2,
                            s.mask, s.ch_en, test_data,
                            reg_read_data);
                    end
                end
                default: begin
                    next_s.mode = HSP_CMD;
                end
            endcase
        end

        // --------------------------------------------------
        // output bit position within the current frame
        out_idx = gray2bin(s.out_s2) - base;
        if (out_idx >= OUT_IDX_NEG) begin
            out_idx = 8'h00;
        end else if (out_idx > OUT_IDX_MAX) begin
            out_idx = OUT_IDX_MAX;
        end
        // bit 7 waits on the pin while deselected
        if (s.cs_s2) begin
            next_s.serial_out = next_s.tx_byte[7];
        end else begin
            next_s.serial_out = s.tx_byte[3'h7 - out_idx[2:0]];
        end

        // --------------------------------------------------
        // interrupt: any unmasked change in either direction
        status_now         = {sig_ch1, sig_ch2};
        changed            = (status_now ^ s.status_prev) & ~s.mask;
        next_s.status_prev = status_now;
        int_set            = |changed;
        // an event in the clearing cycle still wins
        next_s.int_pend = int_set | (s.int_pend & ~int_clr);
        if (int_open_drain) begin
            next_s.int_out = 1'b0;
            next_s.int_oe  = next_s.int_pend;
        end else begin
            next_s.int_out = ~next_s.int_pend;
            next_s.int_oe  = 1'b1;
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s            <= '0;
            s.cs_s1      <= 1'b1;
            s.cs_s2      <= 1'b1;
            s.cs_d       <= 1'b1;
            s.mode       <= HSP_CMD;
            s.ch_en      <= CHAN_EN_RESET;
            s.mask       <= MASK_RESET;
            s.int_out    <= 1'b1;
            s.int_oe     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ========================================================
    // outputs, all straight from flops
    assign serial_out       = s.serial_out;
    assign int_pin_out      = s.int_out;
    assign int_pin_oe       = s.int_oe;
    assign voice_ch1_enable = s.ch_en[EC1_BIT];
    assign voice_ch2_enable = s.ch_en[EC2_BIT];
    assign reg_write        = s.reg_write;
    assign reg_cmd          = s.cmd;
    assign reg_data         = s.reg_data;
    assign device_reset     = s.dev_reset;

endmodule : hsp_host_port

// file: verilog/hsp_pkg.sv
// Notes on behaviour
// - a transaction opens with a command byte, then write or read data bytes.
// - every byte travels most significant bit first, bit 0 last.
// - after a read command, N select periods carry output; commands ignored.
// - voice channel enable bits steer channel-specific register access.
// - serial clock activity while select is high changes nothing.
// - state survives clock idling high; low idle only with select high.
// - a select period with fewer than 8 rising edges is discarded.
// - with 8 to 15 rising edges, the last 8 bits form the byte.
// - 16 or more rising edges in one select period resets the device.
// - first read bit sits on serial output before any clock edge.
// - every interrupt source is maskable; only unmasked changes interrupt.
// - first pending event pulls the interrupt low; events accumulate.
// - clearing signaling read, or test read with alert mode, releases it.
// - an unmasked status change in either direction raises an interrupt.
// - the plain signaling read leaves any pending interrupt untouched.
// - interrupt driver works either push-pull or open-drain.
// - sources: timing loss, two overstress flags, per-channel line events.
// - status byte order, bit 7 down: shared, overstress, thermal, ... hook.
// - masks gate interrupts only, never the reported status values.
package hsp_pkg;

    // ========================================================
    // command codes
    localparam logic [7:0] CMD_WR_CHAN_EN = 8'h4A;
    localparam logic [7:0] CMD_RD_CHAN_EN = 8'h4B;
    localparam logic [7:0] CMD_RD_SIG     = 8'h4D;
    localparam logic [7:0] CMD_RD_SIG_CLR = 8'h4F;
    localparam logic [7:0] CMD_WR_MASK    = 8'h6C;
    localparam logic [7:0] CMD_RD_MASK    = 8'h6D;
    localparam logic [7:0] CMD_RD_TEST    = 8'hCD;

    // ========================================================
    // framing and timing counts
    localparam logic [7:0] MIN_BYTE_EDGES = 8'h08;
    localparam logic [7:0] RESET_EDGES    = 8'h10;
    localparam logic [7:0] OUT_IDX_MAX    = 8'h07;
    localparam logic [7:0] OUT_IDX_NEG    = 8'h80;
    localparam logic [1:0] SETTLE_CYCLES  = 2'h2;

    // ========================================================
    // reset values and field positions
    localparam logic [7:0]  CHAN_EN_RESET = 8'h00;
    localparam logic [15:0] MASK_RESET    = 16'hFFFF;
    localparam int          EC1_BIT       = 0;
    localparam int          EC2_BIT       = 1;

    typedef enum logic [1:0] {
        HSP_CMD,
        HSP_WRITE,
        HSP_READ
    } hsp_mode_type;

    // one signaling status byte, bit 7 first
    typedef struct packed {
        logic shared_flag;
        logic overstress;
        logic thermal_fault;
        logic input_two_change;
        logic ring_cycle_done;
        logic caller_number_ready;
        logic ground_key_change;
        logic hook;
    } hsp_sig_type;

    typedef struct packed {
        logic [7:0] rise_cnt;
        logic [7:0] rise_gray;
        logic [7:0] shift;
    } hsp_link_type;

    typedef struct packed {
        logic         cs_s1;
        logic         cs_s2;
        logic         cs_d;
        logic [7:0]   rise_s1;
        logic [7:0]   rise_s2;
        logic [7:0]   out_s1;
        logic [7:0]   out_s2;
        logic [7:0]   shift_s1;
        logic [7:0]   shift_s2;
        logic [7:0]   rise_base;
        logic [1:0]   settle;
        hsp_mode_type mode;
        logic [7:0]   cmd;
        logic [1:0]   left;
        logic [1:0]   idx;
        logic [7:0]   tx_byte;
        logic         serial_out;
        logic [7:0]   ch_en;
        logic [15:0]  mask;
        logic [15:0]  status_prev;
        logic         int_pend;
        logic         int_out;
        logic         int_oe;
        logic         reg_write;
        logic [7:0]   reg_data;
        logic         dev_reset;
    } hsp_sys_type;

    function automatic logic [7:0] bin2gray(input logic [7:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [7:0] gray2bin(input logic [7:0] g);
        logic [7:0] b;
        b[7] = g[7];
        for (int i = 6; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

endpackage : hsp_pkg

// file: bench/hsp_port_monitor.sv
`timescale 1ns/1ps
module hsp_monitor
    import hsp_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        serial_clock,
    input wire logic        chip_select_b,
    input wire logic        serial_out,
    input wire hsp_sig_type sig_ch1,
    input wire hsp_sig_type sig_ch2,
    input wire logic        int_open_drain,
    input wire logic        int_pin_out,
    input wire logic        int_pin_oe,
    input wire logic        voice_ch1_enable,
    input wire logic        voice_ch2_enable,
    input wire logic        reg_write,
    input wire logic [7:0]  reg_cmd,
    input wire logic        device_reset
);
    // ====
    // helpers
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [15:0] sig_d;
    logic        chg;
    // last status seen, so any change of a bit shows up
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sig_d <= 16'h0000;
        end else begin
            sig_d <= {sig_ch1, sig_ch2};
        end
    end
    assign chg = ({sig_ch1, sig_ch2} != sig_d);
    sequence s_sel_idle;
        chip_select_b [*8] ##1 chip_select_b;
    endsequence
    sequence s_clk_high;
        (!chip_select_b && serial_clock) [*3];
    endsequence
    // ====
    // properties
    property p_sel_idle;
        s_sel_idle |-> $stable(reg_cmd) && !reg_write && !device_reset;
    endproperty
    a_sel_idle: assert property (p_sel_idle)
        else $error("state moved with select high");
    property p_out_hold;
        s_clk_high |-> $stable(serial_out);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("serial_out moved while clock high");
    property p_wr_pulse;
        reg_write |=> !reg_write;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write pulse too long");
    property p_wr_cmd;
        reg_write |-> !reg_cmd[0] && reg_cmd != CMD_WR_CHAN_EN &&
            reg_cmd != CMD_WR_MASK;
    endproperty
    a_wr_cmd: assert property (p_wr_cmd)
        else $error("write pulse for a read command");
    property p_rst_pulse;
        device_reset |=> !device_reset;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset pulse too long");
    property p_rst_clear;
        device_reset |-> ##[0:2] (!voice_ch1_enable && !voice_ch2_enable);
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("enables kept over reset");
    property p_en_cause;
        $changed(voice_ch1_enable) || $changed(voice_ch2_enable) |->
            reg_cmd == CMD_WR_CHAN_EN || device_reset || $past(device_reset);
    endproperty
    a_en_cause: assert property (p_en_cause)
        else $error("enables moved without enable write");
    property p_int_cause;
        $fell(int_pin_out) && !$past(int_open_drain) |->
            $past(chg) || $past(chg, 2);
    endproperty
    a_int_cause: assert property (p_int_cause)
        else $error("interrupt without status change");
    property p_pp_oe;
        !$past(int_open_drain) |-> int_pin_oe;
    endproperty
    a_pp_oe: assert property (p_pp_oe)
        else $error("push-pull pin not driven");
    property p_od_out;
        $past(int_open_drain) && $past(rst_b, 2) |-> !int_pin_out;
    endproperty
    a_od_out: assert property (p_od_out)
        else $error("open-drain pin driven high");
endmodule : hsp_monitor

bind hsp_host_port hsp_monitor mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .serial_clock(serial_clock),
    .chip_select_b(chip_select_b), .serial_out(serial_out),
    .sig_ch1(sig_ch1), .sig_ch2(sig_ch2),
    .int_open_drain(int_open_drain), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe), .voice_ch1_enable(voice_ch1_enable),
    .voice_ch2_enable(voice_ch2_enable), .reg_write(reg_write),
    .reg_cmd(reg_cmd), .device_reset(device_reset)
);

// file: bench/hsp_host_model.sv
`timescale 1ns/1ps
module hsp_host_model (
    output logic      serial_clock,
    output logic      chip_select_b,
    output logic      serial_in,
    input  wire logic serial_out
);
    // ====
    // serial host; clock idles high between frames
    initial begin
        serial_clock = 1'b1;
        chip_select_b = 1'b1;
        serial_in = 1'b0;
    end
    // one select-low period, n rising edges, last 8 carry tx
    task automatic frame(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        logic [15:0] bits;
        bits = {8'hC3, tx}; // leading filler for long frames
        rx = 8'h00;
        chip_select_b = 1'b0;
        #31.3;
        for (int i = n - 1; i >= 0; i--) begin
            serial_clock = 1'b0;
            serial_in = (i < 16) ? bits[i] : 1'b1;
            #15;
            serial_clock = 1'b1;
            rx = {rx[6:0], serial_out};
            #15;
        end
        chip_select_b = 1'b1;
        serial_in = ~serial_in; // released line, no pull
        #60;
    endtask : frame
    // clock run with select high, as a shared clock would
    task automatic burst(input int n);
        repeat (n) begin
            serial_clock = 1'b0;
            serial_in = ~serial_in;
            #15;
            serial_clock = 1'b1;
            #15;
        end
    endtask : burst
endmodule : hsp_host_model

// file: bench/test_serial_host_port_with_irq.sv
`timescale 1ns/1ps
module test_serial_host_port_with_irq
    import hsp_pkg::*;
;
    logic        sys_clk, rst_b, od, alert, sclk, csb, sdi, sdo;
    logic        int_pin_out, int_pin_oe, ch1, ch2, reg_write, dev_rst;
    hsp_sig_type sig_ch1, sig_ch2;
    logic [15:0] test_data, got;
    logic [7:0]  reg_read_data, rx, reg_cmd, reg_data, wr_data;
    int          error_cnt, samples_checked, wr_cnt, rst_cnt;

    hsp_host_port dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .serial_clock(sclk),
        .chip_select_b(csb), .serial_in(sdi), .serial_out(sdo),
        .sig_ch1(sig_ch1), .sig_ch2(sig_ch2),
        .test_data_alert_mode(alert), .int_open_drain(od),
        .test_data(test_data), .reg_read_data(reg_read_data),
        .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
        .voice_ch1_enable(ch1), .voice_ch2_enable(ch2),
        .reg_write(reg_write), .reg_cmd(reg_cmd), .reg_data(reg_data),
        .device_reset(dev_rst)
    );
    hsp_host_model host (
        .serial_clock(sclk), .chip_select_b(csb), .serial_in(sdi),
        .serial_out(sdo)
    );
    // ====
    // clock, pulse catcher, watchdog
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // one-cycle pulses are counted here so no test can miss them
    always @(posedge sys_clk) begin
        if (reg_write === 1'b1) begin
            wr_cnt++;
            wr_data = reg_data;
        end
        if (dev_rst === 1'b1) rst_cnt++;
    end
    // the whole run needs about 31 frames of under 1 us
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
    // ====
    // shared tasks
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] act);
        samples_checked++;
        if (act !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, act);
        end
    endtask : chk
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        host.frame(cmd, 8, rx);
        host.frame(d, 8, rx);
    endtask : wr
    task automatic rd2(input logic [7:0] cmd);
        host.frame(cmd, 8, rx);
        host.frame(8'h00, 8, got[15:8]);
        host.frame(8'h00, 8, got[7:0]);
    endtask : rd2
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // ====
    // scenarios
    task automatic t_chan();
        host.frame(CMD_WR_CHAN_EN, 8, rx);
        chk("cmd", 16'h004A, 16'(reg_cmd));
        host.frame(8'h03, 5, rx);
        chk("en short", 16'h0000, 16'({ch2, ch1}));
        #500;
        host.burst(9);
        chk("en idle", 16'h0000, 16'({ch2, ch1}));
        host.frame(8'h02, 12, rx);
        chk("en last8", 16'h0002, 16'({ch2, ch1}));
        wr(CMD_WR_CHAN_EN, 8'h01);
        chk("en ch1", 16'h0001, 16'({ch2, ch1}));
        host.frame(CMD_RD_CHAN_EN, 8, rx);
        host.frame(8'h00, 8, rx);
        chk("en rd", 16'h0001, 16'(rx));
        $display("t_chan done");
    endtask : t_chan
    task automatic t_rw();
        @(posedge sys_clk) reg_read_data <= 8'h96;
        wr_cnt = 0;
        wr(8'h50, 8'hA5);
        chk("wr", 16'h50A5, {reg_cmd, wr_data});
        chk("wr cnt", 16'h0001, 16'(wr_cnt));
        host.frame(8'h51, 8, rx);
        chk("rd first", 16'h0001, 16'(sdo));
        host.frame(CMD_WR_CHAN_EN, 8, rx);
        chk("rd", 16'h0096, 16'(rx));
        chk("rd cmd", 16'h0051, 16'(reg_cmd));
        $display("t_rw done");
    endtask : t_rw
    task automatic t_irq();
        wr(CMD_WR_MASK, 8'h00);
        host.frame(8'hFF, 8, rx);
        rd2(CMD_RD_MASK);
        chk("mask rd", 16'h00FF, got);
        @(posedge sys_clk) sig_ch2.hook <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("int masked", 16'h0001, 16'(int_pin_out));
        sig_ch1.hook <= 1'b1;
        sig_ch1.ground_key_change <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("int set", 16'h0000, 16'(int_pin_out));
        rd2(CMD_RD_SIG);
        chk("status", 16'h0301, got);
        chk("int kept", 16'h0000, 16'(int_pin_out));
        rd2(CMD_RD_SIG_CLR);
        chk("int clr", 16'h0001, 16'(int_pin_out));
        @(posedge sys_clk) sig_ch1.hook <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk("int fall", 16'h0000, 16'(int_pin_out));
        od <= 1'b1;
        alert <= 1'b1;
        test_data <= 16'h5AC3;
        repeat (3) @(posedge sys_clk);
        chk("od pin", 16'h0001, 16'({int_pin_out, int_pin_oe}));
        rd2(CMD_RD_TEST);
        chk("test", 16'h5AC3, got);
        chk("od clr", 16'h0000, 16'({int_pin_out, int_pin_oe}));
        @(posedge sys_clk) od <= 1'b0;
        $display("t_irq done");
    endtask : t_irq
    task automatic t_long();
        wr(CMD_WR_CHAN_EN, 8'h03);
        rst_cnt = 0;
        host.frame(CMD_WR_CHAN_EN, 16, rx);
        chk("hw rst", 16'h0001, 16'(rst_cnt));
        chk("rst st", 16'h0004, 16'({int_pin_out, ch2, ch1}));
        host.frame(CMD_WR_CHAN_EN, 15, rx);
        host.frame(8'h02, 8, rx);
        chk("no rst", 16'h0001, 16'(rst_cnt));
        chk("en 15", 16'h0002, 16'({ch2, ch1}));
        $display("t_long done");
    endtask : t_long
    initial begin
        rst_b = 1'b0;
        od = 1'b0;
        alert = 1'b0;
        sig_ch1 = '0;
        sig_ch2 = '0;
        test_data = 16'h0000;
        reg_read_data = 8'h00;
        error_cnt = 0;
        samples_checked = 0;
        wr_cnt = 0;
        rst_cnt = 0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_chan();
        t_rw();
        t_irq();
        t_long();
        print_verdict();
    end
endmodule : test_serial_host_port_with_irq
